/* term_route_pkg.sv */
package term_route_pkg;
   // Routing register placement and layout
   localparam logic [7:0] ROUTE_OFFSET = 8'h8c;
   localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;
   localparam int FIELD_W = 4;
   localparam int RSVD_LSB = 28;
   localparam int TERM_COUNT = 7;
   localparam int GPIO_COUNT = 5;
   localparam int SCL_TERM = 4;
   localparam int SDA_TERM = 1;
   localparam int GRANT_TERM = 5;

   // Select codes shared by several terminals
   localparam logic [3:0] CODE_GPI = 4'h0;
   localparam logic [3:0] CODE_SPECIAL = 4'h1;
   localparam logic [3:0] CODE_ALT2 = 4'h2;
   localparam logic [3:0] CODE_IRQ5 = 4'h5;
   localparam logic [3:0] CODE_VSTAT = 4'h6;
   localparam logic [3:0] CODE_VSEL = 4'h7;
   localparam logic [3:0] CODE_AUDIO = 4'h8;
   localparam logic [3:0] CODE_RING_LED = 4'hc;
   localparam logic [3:0] CODE_ALTD = 4'hd;
   localparam logic [3:0] CODE_EVENT = 4'he;
   localparam logic [3:0] CODE_ALTF = 4'hf;

   // Positions in the internal source vector; 0..15 are interrupt lines
   localparam int SRC_CLKRUN = 16;
   localparam int SRC_SERIRQ = 17;
   localparam int SRC_INTA = 18;
   localparam int SRC_DMAREQ = 19;
   localparam int SRC_VSTAT = 20;
   localparam int SRC_VSEL = 21;
   localparam int SRC_AUDIO = 22;
   localparam int SRC_LED = 23;
   localparam int SRC_EVENT = 24;
   localparam int SRC_RING = 25;
   localparam int SRC_GPO = 26;
   localparam int SRC_W = 31;
   localparam int IRQ7 = 7;
   localparam int IRQ13 = 13;
   localparam int IRQ15 = 15;
endpackage

/* terminal_select.sv */
`timescale 1ns/100ps
module terminal_select #(
   parameter int TERM = 0
) (
   input wire logic [3:0] code, // Routing field of this terminal
   input wire logic [30:0] src, // Internal source signals
   input wire logic dma_en, // Centralized DMA enable
   input wire logic ring_en, // Ring output enable
   input wire logic audio_en, // Card audio routing enable
   output logic drive, // Terminal is driven
   output logic value, // Level driven
   output logic is_gpi, // Terminal is a general input
   output logic is_grant // Terminal is the DMA grant input
);
   localparam int GIDX = (TERM < 3) ? TERM
                       : ((TERM == 4) || (TERM == 5)) ? TERM - 1 : 0;
   localparam bit IRQ_TERM = (TERM == 3) || (TERM == 6);

   always_comb begin
      drive = 1'b1;
      value = 1'b0;
      is_gpi = 1'b0;
      is_grant = 1'b0;
      if (IRQ_TERM) begin
         case (code)
            term_route_pkg::CODE_GPI: drive = 1'b0;
            term_route_pkg::CODE_SPECIAL: begin
               value = src[TERM == 6 ? term_route_pkg::SRC_CLKRUN
                                     : term_route_pkg::SRC_SERIRQ];
            end
            default: value = src[code];
         endcase
      end else begin
         case (code)
            term_route_pkg::CODE_GPI: begin
               drive = 1'b0;
               is_gpi = 1'b1;
            end
            term_route_pkg::CODE_SPECIAL: begin
               value = src[term_route_pkg::SRC_GPO + GIDX];
            end
            term_route_pkg::CODE_ALT2: begin
               if (TERM == 0) begin
                  value = src[term_route_pkg::SRC_INTA];
               end else if (TERM == 2) begin
                  drive = dma_en;
                  value = src[term_route_pkg::SRC_DMAREQ];
               end else if (TERM == 5) begin
                  drive = 1'b0;
                  is_grant = dma_en;
               end else begin
                  drive = 1'b0;
               end
            end
            term_route_pkg::CODE_IRQ5: begin
               drive = (TERM != 5);
               value = src[code];
            end
            term_route_pkg::CODE_VSTAT: begin
               value = src[term_route_pkg::SRC_VSTAT];
            end
            term_route_pkg::CODE_VSEL: begin
               value = src[term_route_pkg::SRC_VSEL];
            end
            term_route_pkg::CODE_AUDIO: begin
               drive = audio_en;
               value = src[term_route_pkg::SRC_AUDIO];
            end
            term_route_pkg::CODE_RING_LED: begin
               if (TERM == 2 || TERM == 4) begin
                  drive = ring_en;
                  value = src[term_route_pkg::SRC_RING];
               end else begin
                  value = src[term_route_pkg::SRC_LED];
               end
            end
            term_route_pkg::CODE_ALTD: begin
               if (TERM == 2) begin
                  drive = 1'b0;
               end else if (TERM == 4 || TERM == 5) begin
                  value = src[term_route_pkg::SRC_LED];
               end else begin
                  value = src[term_route_pkg::IRQ13];
               end
            end
            term_route_pkg::CODE_EVENT: begin
               value = src[term_route_pkg::SRC_EVENT];
            end
            term_route_pkg::CODE_ALTF: begin
               value = src[TERM == 2 ? term_route_pkg::IRQ7
                                     : term_route_pkg::IRQ15];
            end
            default: value = src[code];
         endcase
      end
   end
endmodule // terminal_select

/* terminal_routing.sv */
`timescale 1ns/100ps
// How it works
// - Routing register resets to all zeros.
// - EEPROM load replaces the routing default.
// - Bits 31..28 read zero, ignore writes.
// - Terminal 6: reserved, clock-run, interrupts 2..15.
// - Terminal 5 code table applies.
// - Terminal 4 upper codes: ring, LED, event, 15.
// - Serial-bus strap dedicates terminals 1 and 4 to bus.
// - Terminal 3: reserved, serial interrupt, 2..15.
// - Terminal 2 code table applies.
// - Terminal 1 code table applies.
// - Terminal 0 code table applies.
// - DMA request/grant need central DMA enable.
// - Ring output needs ring enable bit.
// - Card audio appears when routing bit set.
module terminal_routing (
   input wire logic CLOCK, // PCI clock
   input wire logic RESET, // Synchronous reset, active high
   input wire logic CFG_WR, // Config write strobe
   input wire logic CFG_RD, // Config read strobe
   input wire logic [7:0] CFG_ADDR, // Config byte address
   input wire logic [3:0] CFG_BE, // Config byte enables
   input wire logic [31:0] CFG_WDATA, // Config write data
   output logic [31:0] CFG_RDATA, // Config read data
   input wire logic EE_LOAD_VALID, // EEPROM routing word strobe
   input wire logic [31:0] EE_LOAD_DATA, // EEPROM routing word
   input wire logic VCC_CONTROL_0, // Strap level of VCC control 0
   input wire logic VCC_CONTROL_1, // Strap level of VCC control 1
   input wire logic CENTRAL_DMA_ENABLE, // Centralized DMA enable
   input wire logic RING_OUT_ENABLE, // Ring output enable
   input wire logic CARD_AUDIO_ROUTE, // Card audio routing enable
   input wire logic [15:0] IRQ_LINES, // Interrupt line levels
   input wire logic CLKRUN_OUT, // Clock-run level
   input wire logic SERIALIZED_INTERRUPT, // Serial interrupt level
   input wire logic PCI_INTA, // PCI INTA level
   input wire logic DMA_REQUEST_OUT, // PC/PCI DMA request
   input wire logic VIDEO_PORT_STATUS, // Video port status
   input wire logic VIDEO_PORT_SELECT0, // Video port select 0
   input wire logic CARD_AUDIO_PWM, // Card audio PWM
   input wire logic SOCKET_ACTIVITY_LED, // Socket activity LED
   input wire logic GENERAL_PURPOSE_EVENT, // Event output level
   input wire logic RING_INDICATE_OUT, // Ring indicate level
   input wire logic [4:0] GENERAL_OUTPUT, // General outputs
   input wire logic SDA_DRIVE_LOW, // Pull serial data low
   input wire logic SCL_DRIVE_LOW, // Pull serial clock low
   input wire logic [6:0] MULTI_PIN_IN, // Terminal levels
   output logic [6:0] MULTI_PIN_OUT, // Terminal drive values
   output logic [6:0] MULTI_PIN_OE_N, // Terminal enables, low drives
   output logic [4:0] GENERAL_INPUT, // General inputs
   output logic DMA_GRANT_IN, // PC/PCI DMA grant
   output logic SDA_IN, // Serial data level
   output logic SCL_IN, // Serial clock level
   output logic SERIAL_MODE // Serial-bus strap seen
);
   ////////////////////////////////////////////////////////////////////////
   logic [31:0] route_r;
   logic [31:0] route_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [6:0] out_r;
   logic [6:0] out_nxt;
   logic [6:0] oe_n_r;
   logic [6:0] oe_n_nxt;
   logic [4:0] gpi_r;
   logic [4:0] gpi_nxt;
   logic grant_r;
   logic grant_nxt;
   logic sda_r;
   logic sda_nxt;
   logic scl_r;
   logic scl_nxt;
   logic serial_r;
   logic serial_nxt;
   logic [30:0] src;
   logic [6:0] drive;
   logic [6:0] value;
   logic [6:0] is_gpi;
   logic [6:0] is_grant;
   logic hit;

   assign src = {GENERAL_OUTPUT, RING_INDICATE_OUT, GENERAL_PURPOSE_EVENT,
                 SOCKET_ACTIVITY_LED, CARD_AUDIO_PWM, VIDEO_PORT_SELECT0,
                 VIDEO_PORT_STATUS, DMA_REQUEST_OUT, PCI_INTA,
                 SERIALIZED_INTERRUPT, CLKRUN_OUT, IRQ_LINES};
   assign hit = (CFG_ADDR[7:2] == term_route_pkg::ROUTE_OFFSET[7:2]);

   ////////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < term_route_pkg::TERM_COUNT; g++) begin : g_term
         terminal_select #(
            .TERM(g)
         ) u_sel (
            .code(route_r[g*term_route_pkg::FIELD_W +: 4]),
            .src(src),
            .dma_en(CENTRAL_DMA_ENABLE),
            .ring_en(RING_OUT_ENABLE),
            .audio_en(CARD_AUDIO_ROUTE),
            .drive(drive[g]),
            .value(value[g]),
            .is_gpi(is_gpi[g]),
            .is_grant(is_grant[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      route_nxt = route_r;
      if (EE_LOAD_VALID) begin
         route_nxt = EE_LOAD_DATA;
      end else if (CFG_WR && hit) begin
         for (int b = 0; b < 4; b++) begin
            if (CFG_BE[b]) begin
               route_nxt[8*b +: 8] = CFG_WDATA[8*b +: 8];
            end
         end
      end
      route_nxt[31:term_route_pkg::RSVD_LSB] = 4'h0;
      rdata_nxt = (CFG_RD && hit) ? route_r : 32'h0000_0000;
   end

   always_comb begin
      out_nxt = value;
      oe_n_nxt = ~drive;
      if (serial_r) begin
         out_nxt[term_route_pkg::SDA_TERM] = 1'b0;
         oe_n_nxt[term_route_pkg::SDA_TERM] = ~SDA_DRIVE_LOW;
         out_nxt[term_route_pkg::SCL_TERM] = 1'b0;
         oe_n_nxt[term_route_pkg::SCL_TERM] = ~SCL_DRIVE_LOW;
      end
      gpi_nxt = {MULTI_PIN_IN[5] & is_gpi[5],
                 MULTI_PIN_IN[4] & is_gpi[4] & ~serial_r,
                 MULTI_PIN_IN[2:0] & is_gpi[2:0]};
      gpi_nxt[1] = MULTI_PIN_IN[1] & is_gpi[1] & ~serial_r;
      grant_nxt = MULTI_PIN_IN[term_route_pkg::GRANT_TERM] &
                  is_grant[term_route_pkg::GRANT_TERM];
      sda_nxt = MULTI_PIN_IN[term_route_pkg::SDA_TERM];
      scl_nxt = MULTI_PIN_IN[term_route_pkg::SCL_TERM];
      // Strap level is only taken while reset is held
      serial_nxt = RESET ? (VCC_CONTROL_0 & VCC_CONTROL_1) : serial_r;
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         route_r <= term_route_pkg::ROUTE_RESET;
         rdata_r <= 32'h0000_0000;
         out_r <= 7'h00;
         oe_n_r <= 7'h7f;
         gpi_r <= 5'h00;
         grant_r <= 1'b0;
         sda_r <= 1'b0;
         scl_r <= 1'b0;
         serial_r <= serial_nxt;
      end else begin
         route_r <= route_nxt;
         rdata_r <= rdata_nxt;
         out_r <= out_nxt;
         oe_n_r <= oe_n_nxt;
         gpi_r <= gpi_nxt;
         grant_r <= grant_nxt;
         sda_r <= sda_nxt;
         scl_r <= scl_nxt;
         serial_r <= serial_nxt;
      end
   end

   assign CFG_RDATA = rdata_r;
   assign MULTI_PIN_OUT = out_r;
   assign MULTI_PIN_OE_N = oe_n_r;
   assign GENERAL_INPUT = gpi_r;
   assign DMA_GRANT_IN = grant_r;
   assign SDA_IN = sda_r;
   assign SCL_IN = scl_r;
   assign SERIAL_MODE = serial_r;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RESET);

   sequence s_ee_load;
      EE_LOAD_VALID;
   endsequence

   sequence s_then_read;
      ##1 (CFG_RD && hit) ##1 1'b1;
   endsequence

   a_reset_zero: assert property (@(posedge CLOCK) disable iff (1'b0)
      $past(RESET) |-> route_r == 32'h0000_0000)
      else $error("routing not zero after reset");
   a_top_zero: assert property (CFG_RD && hit
      |=> CFG_RDATA[31:28] == 4'h0)
      else $error("reserved routing bits not zero");
   a_ee_default: assert property (s_ee_load
      ##1 !EE_LOAD_VALID && !CFG_WR
      |-> route_r[27:0] == $past(EE_LOAD_DATA[27:0]))
      else $error("eeprom word not loaded");
   a_read_back: assert property (s_ee_load ##0 s_then_read
      |-> CFG_RDATA == {4'h0, $past(EE_LOAD_DATA[27:0], 2)})
      else $error("eeprom word not read back");
   a_clkrun_route: assert property (route_r[27:24] == 4'h1
      |=> !MULTI_PIN_OE_N[6] && MULTI_PIN_OUT[6] == $past(CLKRUN_OUT))
      else $error("clock-run not routed");
   a_reserved_in: assert property (route_r[27:24] == 4'h0
      |=> MULTI_PIN_OE_N[6])
      else $error("reserved code drives terminal");
   a_dma_gate: assert property (route_r[11:8] == 4'h2
      && !CENTRAL_DMA_ENABLE |=> MULTI_PIN_OE_N[2])
      else $error("dma request without enable");
   a_ring_gate: assert property (route_r[11:8] == 4'hc
      |=> MULTI_PIN_OE_N[2] == !$past(RING_OUT_ENABLE))
      else $error("ring output gating wrong");
   a_audio_route: assert property (route_r[3:0] == 4'h8
      && CARD_AUDIO_ROUTE |=> !MULTI_PIN_OE_N[0]
      && MULTI_PIN_OUT[0] == $past(CARD_AUDIO_PWM))
      else $error("card audio not routed");
   a_serial_clock: assert property (SERIAL_MODE
      |=> MULTI_PIN_OE_N[4] == !$past(SCL_DRIVE_LOW) && !MULTI_PIN_OUT[4])
      else $error("serial clock terminal wrong");
   a_serial_data: assert property (SERIAL_MODE
      |=> MULTI_PIN_OE_N[1] == !$past(SDA_DRIVE_LOW))
      else $error("serial data terminal wrong");
endmodule // terminal_routing

/* board_side.sv */
`timescale 1ns/100ps
module board_side (
   input wire logic clock, // Board clock
   input wire logic [6:0] pin_out, // Device drive values
   input wire logic [6:0] pin_oe_n, // Device enables, low drives
   input wire logic serial_mode, // Serial strap in force
   output logic [6:0] pin_level // Resolved terminal levels
);
   logic [6:0] ext_r = 7'h5a;

   // Board keeps every floated terminal moving, except terminals 1 and 4 in serial mode, so stale levels never pass
   always @(posedge clock) begin
      ext_r <= {ext_r[5:0], ext_r[6] ^ ext_r[5]};
   end

   always_comb begin
      for (int i = 0; i < 7; i++) begin
         pin_level[i] = pin_oe_n[i] ? ext_r[i] : pin_out[i];
      end
      // Serial lines are open drain with pull-ups
      if (serial_mode) begin
         pin_level[1] = pin_oe_n[1];
         pin_level[4] = pin_oe_n[4];
      end
   end
endmodule // board_side

/* testbench.sv */
`timescale 1ns/100ps
module testbench;
   logic clk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, ee_valid = 0;
   logic [7:0] cfg_addr = 8'h8c;
   logic [3:0] cfg_be = 4'hf;
   logic [31:0] cfg_wdata = 32'h0, ee_data = 32'h0, rdata;
   logic vcc0 = 0, vcc1 = 0, dma_en = 0, ring_en = 0, aud_en = 0;
   logic sda_low = 0, scl_low = 0, grant, sda_in, scl_in, serial, hit;
   logic [15:0] irq = 16'h0;
   logic [9:0] src = 10'h0;
   logic [4:0] gpo = 5'h0, gin, exp_gi_r;
   logic [6:0] pin_in, pin_out, pin_oe_n, exp_oe_r, exp_out_r;
   logic [31:0] route_r = 32'h0, exp_rd_r;
   logic serial_r = 0, exp_grant_r, exp_sda_r, exp_scl_r, checking = 0;
   int error_cnt = 0, n_tests = 0, seed = 32'hd882;

   terminal_routing DUT (.CLOCK(clk), .RESET(rst), .CFG_WR(cfg_wr),
      .CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr), .CFG_BE(cfg_be),
      .CFG_WDATA(cfg_wdata), .CFG_RDATA(rdata), .EE_LOAD_VALID(ee_valid),
      .EE_LOAD_DATA(ee_data), .VCC_CONTROL_0(vcc0), .VCC_CONTROL_1(vcc1),
      .CENTRAL_DMA_ENABLE(dma_en), .RING_OUT_ENABLE(ring_en),
      .CARD_AUDIO_ROUTE(aud_en), .IRQ_LINES(irq), .CLKRUN_OUT(src[0]),
      .SERIALIZED_INTERRUPT(src[1]), .PCI_INTA(src[2]),
      .DMA_REQUEST_OUT(src[3]), .VIDEO_PORT_STATUS(src[4]),
      .VIDEO_PORT_SELECT0(src[5]), .CARD_AUDIO_PWM(src[6]),
      .SOCKET_ACTIVITY_LED(src[7]), .GENERAL_PURPOSE_EVENT(src[8]),
      .RING_INDICATE_OUT(src[9]), .GENERAL_OUTPUT(gpo),
      .SDA_DRIVE_LOW(sda_low), .SCL_DRIVE_LOW(scl_low),
      .MULTI_PIN_IN(pin_in), .MULTI_PIN_OUT(pin_out),
      .MULTI_PIN_OE_N(pin_oe_n), .GENERAL_INPUT(gin), .DMA_GRANT_IN(grant),
      .SDA_IN(sda_in), .SCL_IN(scl_in), .SERIAL_MODE(serial));

   board_side board (.clock(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .serial_mode(serial), .pin_level(pin_in));

   assign hit = (cfg_addr >> 2) == (term_route_pkg::ROUTE_OFFSET >> 2);

   initial begin
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Reference: {drive, value} of terminal t for select code c
   function automatic logic [1:0] pick(input int t, input logic [3:0] c);
      if (t == 6 || t == 3)
         return (c == 4'h0) ? 2'b00 :
            (c == 4'h1) ? {1'b1, src[(t == 6) ? 0 : 1]} : {1'b1, irq[c]};
      case (c)
         4'h0: return 2'b00;
         4'h1: return {1'b1, gpo[(t < 3) ? t : t - 1]};
         4'h2: return (t == 0) ? {1'b1, src[2]} :
            (t == 2 && dma_en) ? {1'b1, src[3]} : 2'b00;
         4'h5: return (t == 5) ? 2'b00 : {1'b1, irq[5]};
         4'h6: return {1'b1, src[4]};
         4'h7: return {1'b1, src[5]};
         4'h8: return aud_en ? {1'b1, src[6]} : 2'b00;
         4'hc: return (t == 2 || t == 4) ?
            (ring_en ? {1'b1, src[9]} : 2'b00) : {1'b1, src[7]};
         4'hd: return (t == 2) ? 2'b00 :
            (t > 3) ? {1'b1, src[7]} : {1'b1, irq[13]};
         4'he: return {1'b1, src[8]};
         4'hf: return {1'b1, irq[(t == 2) ? 7 : 15]};
         default: return {1'b1, irq[c]};
      endcase
   endfunction

   // Model samples the same inputs the design registers at this edge
   always @(posedge clk) begin : model
      logic [1:0] dv;
      logic [6:0] oe, ov;
      logic [4:0] gi;
      logic [31:0] nw;
      int tm;
      if (rst) begin
         {exp_oe_r, exp_out_r, exp_gi_r, exp_grant_r} <= {7'h7f, 13'h0};
         exp_rd_r <= 32'h0;
         route_r <= term_route_pkg::ROUTE_RESET;
         serial_r <= vcc0 & vcc1;
         {exp_sda_r, exp_scl_r} <= 2'b00;
      end else begin
         for (int t = 0; t < 7; t++) begin
            dv = pick(t, route_r[4*t +: 4]);
            if (serial_r && (t == 1 || t == 4))
               dv = {(t == 1) ? sda_low : scl_low, 1'b0};
            oe[t] = !dv[1];
            ov[t] = dv[1] & dv[0];
         end
         for (int i = 0; i < 5; i++) begin
            tm = (i < 3) ? i : i + 1;
            gi[i] = route_r[4*tm +: 4] == 4'h0 &&
               !(serial_r && (tm == 1 || tm == 4)) && pin_in[tm];
         end
         exp_oe_r <= oe;
         exp_out_r <= ov;
         exp_gi_r <= gi;
         exp_grant_r <= route_r[23:20] == 4'h2 && dma_en && pin_in[5];
         exp_rd_r <= (cfg_rd && hit) ? route_r : 32'h0;
         nw = route_r;
         for (int b = 0; b < 4; b++) begin
            if (cfg_be[b]) nw[8*b +: 8] = cfg_wdata[8*b +: 8];
         end
         if (ee_valid) route_r <= ee_data & 32'h0fff_ffff;
         else if (cfg_wr && hit) route_r <= nw & 32'h0fff_ffff;
         exp_sda_r <= pin_in[1];
         exp_scl_r <= pin_in[4];
      end
   end

   task check(input string name, input logic [31:0] seen,
         input logic [31:0] expv);
      n_tests++;
      if (seen !== expv) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, expv, seen);
      end
   endtask

   always @(negedge clk) begin
      if (checking) begin
         check("oe_n", pin_oe_n, exp_oe_r);
         check("out", pin_out & ~exp_oe_r, exp_out_r);
         check("gen_in", gin, exp_gi_r);
         check("grant", grant, exp_grant_r);
         check("rdata", rdata, exp_rd_r);
         check("serial", serial, serial_r);
         check("sda", sda_in, exp_sda_r);
         check("scl", scl_in, exp_scl_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task step(input int op);
      @(posedge clk);
      irq <= 16'($random(seed));
      src <= 10'($random(seed));
      gpo <= 5'($random(seed));
      {dma_en, ring_en, aud_en, sda_low, scl_low} <= 5'($random(seed));
      cfg_wr <= (op == 0 || op == 3);
      cfg_rd <= (op == 1);
      ee_valid <= (op == 2 || op == 3);
      cfg_addr <= ($random(seed) % 6 == 0) ? 8'($random(seed)) : 8'h8c;
      cfg_be <= 4'($random(seed));
      cfg_wdata <= $random(seed);
      ee_data <= $random(seed);
   endtask

   task print_verdict;
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      #(20 * 10000);
      error_cnt++;
      print_verdict;
   end

   initial begin
      @(posedge clk);
      checking <= 1;
      for (int ph = 0; ph < 2; ph++) begin
         @(posedge clk);
         rst <= 1;
         // Drop strobes left over from the previous phase
         cfg_wr <= 0;
         cfg_rd <= 0;
         ee_valid <= 0;
         {vcc0, vcc1} <= (ph == 1) ? 2'b11 : 2'b01;
         repeat (16) @(posedge clk);
         rst <= 0;
         step(1);
         step(2);
         step(1);
         // One-time programming, then deliberate churn for coverage
         step(0);
         repeat (3000) step($unsigned($random(seed)) % 6);
      end
      step(4);
      repeat (2) @(posedge clk);
      print_verdict;
   end
endmodule // testbench
